// ==== analog_source_model.sv ====
// Analog side model: fixed level per input and the RC oscillator tick.
// Assumes the comparator sees the trial code of the same cycle.
`timescale 1ns/1ps
`default_nettype none
module analog_source_model
  import sar_adc_pkg::*;
#(
  parameter int RC_HALF = 3
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [SEL_W-1:0] input_select,
  input  wire logic [9:0]       sar_trial_code,
  output logic                  compare_high,
  output logic                  rc_half_tick
);
  // Each input holds the select code written twice, so results differ
  wire logic [9:0] level = {input_select, input_select};
  int              cnt;
  // Pins act as analog inputs with drivers off: only levels arrive
  assign compare_high = (level >= sar_trial_code);
  // The RC oscillator runs free, unrelated to any conversion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      rc_half_tick <= 1'b0;
    end else begin
      cnt <= (cnt == RC_HALF - 1) ? 0 : cnt + 1;
      rc_half_tick <= (cnt == RC_HALF - 1);
    end
  end
endmodule
`default_nettype wire

// ==== sar_adc_checker.sv ====
// Port checker for the converter control block.
// Assumes one clock domain; bound onto every design instance.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        core_sleeping,
  input wire logic        conversion_done_flag,
  input wire logic        irq_request,
  input wire logic        wake_request,
  input wire logic        resume_next_instr,
  input wire logic        isr_branch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire logic take = hsel & hready & htrans[1];
  wire logic wr_flag = take & hwrite & (haddr[7:0] == ADDR_FLAG);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  a_flag_clear: assert property (
    $fell(conversion_done_flag) |-> $past(wr_flag, 2))
    else $error("done flag dropped without a software write");
  // Request and flag are loaded at the same edge
  a_irq_gated: assert property (
    irq_request |-> conversion_done_flag)
    else $error("interrupt request without done flag");
  a_wake_cause: assert property (
    wake_request |-> conversion_done_flag && $past(core_sleeping))
    else $error("wake request without completion in sleep");
  a_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
  a_resume_next: assert property (
    wake_request |=> resume_next_instr)
    else $error("no resume after wake request");
  a_resume_only: assert property (
    resume_next_instr |-> $past(wake_request))
    else $error("resume without wake request");
  a_isr_order: assert property (isr_branch |-> $past(resume_next_instr))
    else $error("handler branch before resume");
  c_wake: cover property (wake_request);
  c_isr: cover property (isr_branch);
  c_done: cover property ($rose(conversion_done_flag));
  c_read: cover property (take && !hwrite);
endmodule
bind sar_adc_control sar_adc_checker chk_u (.*);
`default_nettype wire

// ==== sar_adc_control.sv ====
// Control logic of a 10-bit successive-approximation converter with an
// AHB-Lite register slave, clock divider, flag and sleep wake-up.
// Assumes the analog comparator result is synchronous to clock.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        compare_high,
  input  wire logic        rc_half_tick,
  input  wire logic        core_sleeping,
  output logic [SEL_W-1:0] input_select,
  output logic [PREF_W-1:0] upper_reference_select,
  output logic             lower_reference_select,
  output logic             converter_on,
  output logic             sample_connect,
  output logic [9:0]       sar_trial_code,
  output logic             conversion_done_flag,
  output logic             irq_request,
  output logic             wake_request,
  output logic             resume_next_instr,
  output logic             isr_branch
);

  // Bus slave state
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  waddr_reg;
  logic        hreadyout_reg;
  logic [31:0] hrdata_reg;

  // Software registers
  logic             on_reg;
  logic [SEL_W-1:0] sel_reg;
  logic             just_reg;
  logic [CS_W-1:0]  cs_reg;
  logic             nref_reg;
  logic [PREF_W-1:0] pref_reg;
  logic             flag_reg;
  logic             flag_next;
  logic             irqen_reg;
  logic             gie_reg;
  logic             peripheral_irq_enable_reg;
  logic [7:0]       res_hi_reg;
  logic [7:0]       res_lo_reg;

  // Conversion state
  conv_state_e      state_reg;
  conv_state_e      state_next;
  logic [4:0]       half_reg;
  logic [4:0]       half_next;
  logic [9:0]       sar_reg;
  logic [9:0]       sar_next;
  logic [9:0]       mask_reg;
  logic [9:0]       mask_next;
  logic             pd_reg;
  logic             pd_next;

  // Wake sequence and outputs
  logic             wake_reg;
  logic             resume_reg;
  logic             isr_reg;
  logic             irq_reg;
  logic             on_out_reg;
  logic             sample_reg;

  // Right-justified: hi = 000000 r9 r8, lo = r7..r0.
  // Left-justified:  hi = r9..r2, lo = r1 r0 000000.
  function automatic logic [15:0] justify(input logic [9:0] r,
                                          input logic       right);
    if (right)
      justify = {6'h00, r[9:8], r[7:0]};
    else
      justify = {r[9:2], r[1:0], 6'h00};
  endfunction

  // Undecided bits copy the last decided bit; none decided gives zero
  function automatic logic [9:0] partial(input logic [9:0] s,
                                         input logic [9:0] m);
    logic [9:0] low;
    logic       last;
    low  = m | (m - 10'h001);
    last = |(s & {m[8:0], 1'b0});
    if (m == SAR_FIRST_MASK)
      partial = 10'h000;
    else
      partial = (s & ~low) | (last ? low : 10'h000);
  endfunction

  // Bus decode
  wire        addr_ok   = hsel && hready && htrans[1];
  wire        wr_fire   = wr_pend_reg && hready;
  wire        wr_ctrl0  = wr_fire && waddr_reg == ADDR_CTRL0;
  wire        wr_ctrl1  = wr_fire && waddr_reg == ADDR_CTRL1;
  wire        wr_flag   = wr_fire && waddr_reg == ADDR_FLAG;
  wire        wr_irqen  = wr_fire && waddr_reg == ADDR_IRQ_EN;
  wire        wr_core   = wr_fire && waddr_reg == ADDR_CORE;
  wire        busy      = state_reg != ST_IDLE;

  wire [7:0]  ctrl0_rd  = {1'b0, sel_reg, busy, on_reg};
  wire [7:0]  ctrl1_rd  = {just_reg, cs_reg, 1'b0, nref_reg, pref_reg};
  wire [7:0]  core_rd   = {gie_reg, peripheral_irq_enable_reg, 6'h00};

  wire [7:0]  rd_byte =
    (waddr_reg == ADDR_CTRL0)  ? ctrl0_rd :
    (waddr_reg == ADDR_CTRL1)  ? ctrl1_rd :
    (waddr_reg == ADDR_RES_HI) ? res_hi_reg :
    (waddr_reg == ADDR_RES_LO) ? res_lo_reg :
    (waddr_reg == ADDR_FLAG)   ? {7'h00, flag_reg} :
    (waddr_reg == ADDR_IRQ_EN) ? {7'h00, irqen_reg} :
    (waddr_reg == ADDR_CORE)   ? core_rd : 8'h00;

  // Conversion control
  wire        rc_sel      = is_rc(cs_reg);
  wire        sleep_block = core_sleeping && !rc_sel;
  wire        start       = wr_ctrl0 && hwdata[CTRL0_GO_BIT] && on_reg
                            && !busy && !sleep_block && !pd_reg;
  wire        sw_abort    = wr_ctrl0 && busy && !hwdata[CTRL0_GO_BIT];
  wire        off_abort   = wr_ctrl0 && busy && !hwdata[CTRL0_ON_BIT];
  wire        sleep_abort = busy && sleep_block;
  wire        half_tick;
  wire        conv_tick   = half_tick && state_reg == ST_CONV;
  wire        decide      = conv_tick && half_reg >= FIRST_DECIDE
                            && !half_reg[0];
  wire        finish      = conv_tick && half_reg == CONV_LAST_HALF;
  wire        done_evt    = finish && !sw_abort && !off_abort
                            && !sleep_abort;
  wire        part_load   = sw_abort && !off_abort && !sleep_abort;
  wire [9:0]  trial_keep  = compare_high ? sar_reg : (sar_reg & ~mask_reg);
  wire [9:0]  decided     = trial_keep | (mask_reg >> 1);
  wire [15:0] done_word   = justify(decided, just_reg);
  wire [15:0] part_word   = justify(partial(sar_reg, mask_reg),
                                    just_reg);

  tad_tick_gen #(
    .DIV_W (5)
  ) u_tick (
    .clock        (clock),
    .nrst         (nrst),
    .run          (busy),
    .clock_select (cs_reg),
    .rc_half_tick (rc_half_tick),
    .half_tick    (half_tick)
  );

  // Sequencer
  always_comb begin
    state_next = state_reg;
    half_next  = half_reg;
    sar_next   = sar_reg;
    mask_next  = mask_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          // RC clock waits one bit period so the core can go to sleep
          state_next = rc_sel ? ST_WAIT : ST_CONV;
          half_next  = 5'h00;
          sar_next   = SAR_FIRST_MASK;
          mask_next  = SAR_FIRST_MASK;
        end
      end
      ST_WAIT: begin
        if (half_tick) begin
          half_next = half_reg + 5'h01;
          if (half_reg == RC_START_HALVES - 5'h01) begin
            state_next = ST_CONV;
            half_next  = 5'h00;
          end
        end
      end
      ST_CONV: begin
        if (conv_tick)
          half_next = half_reg + 5'h01;
        if (decide) begin
          sar_next  = decided;
          mask_next = mask_reg >> 1;
        end
        if (finish)
          state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (sw_abort || off_abort || sleep_abort)
      state_next = ST_IDLE;
  end

  // Sticky done flag, set wins over a software clear
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag)
      flag_next = hwdata[FLAG_DONE_BIT];
    if (done_evt)
      flag_next = 1'b1;
  end

  // Power-down in sleep: non-RC clock, or finished with irq disabled
  always_comb begin
    pd_next = pd_reg;
    if (!core_sleeping)
      pd_next = 1'b0;
    else if (sleep_block || (done_evt && !irqen_reg))
      pd_next = 1'b1;
  end

  // Bus slave: writes have no wait state, reads have one
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      waddr_reg     <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= 32'h0000_0000;
    end else begin
      if (addr_ok)
        waddr_reg <= haddr[7:0];
      wr_pend_reg   <= addr_ok && hwrite;
      rd_pend_reg   <= addr_ok && !hwrite;
      hreadyout_reg <= !(addr_ok && !hwrite);
      if (rd_pend_reg)
        hrdata_reg <= {24'h000000, rd_byte};
    end
  end

  // Software control registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      on_reg    <= CTRL0_RST[CTRL0_ON_BIT];
      sel_reg   <= CTRL0_RST[CTRL0_SEL_LSB +: SEL_W];
      just_reg  <= CTRL1_RST[CTRL1_JUST_BIT];
      cs_reg    <= CTRL1_RST[CTRL1_CS_LSB +: CS_W];
      nref_reg  <= CTRL1_RST[CTRL1_NREF_BIT];
      pref_reg  <= CTRL1_RST[CTRL1_PREF_LSB +: PREF_W];
      irqen_reg <= 1'b0;
      gie_reg   <= 1'b0;
      peripheral_irq_enable_reg  <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        on_reg  <= hwdata[CTRL0_ON_BIT];
        sel_reg <= hwdata[CTRL0_SEL_LSB +: SEL_W];
      end
      if (wr_ctrl1) begin
        just_reg <= hwdata[CTRL1_JUST_BIT];
        cs_reg   <= hwdata[CTRL1_CS_LSB +: CS_W];
        nref_reg <= hwdata[CTRL1_NREF_BIT];
        pref_reg <= hwdata[CTRL1_PREF_LSB +: PREF_W];
      end
      if (wr_irqen)
        irqen_reg <= hwdata[IRQ_EN_BIT];
      if (wr_core) begin
        gie_reg  <= hwdata[CORE_GIE_BIT];
        peripheral_irq_enable_reg <= hwdata[CORE_PERIPHERAL_IRQ_ENABLE_BIT];
      end
    end
  end

  // Conversion datapath and result pair
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= ST_IDLE;
      half_reg   <= 5'h00;
      sar_reg    <= 10'h000;
      mask_reg   <= SAR_FIRST_MASK;
      res_hi_reg <= RES_RST;
      res_lo_reg <= RES_RST;
      flag_reg   <= 1'b0;
      pd_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      half_reg  <= half_next;
      sar_reg   <= sar_next;
      mask_reg  <= mask_next;
      flag_reg  <= flag_next;
      pd_reg    <= pd_next;
      if (done_evt) begin
        res_hi_reg <= done_word[15:8];
        res_lo_reg <= done_word[7:0];
      end else if (part_load) begin
        res_hi_reg <= part_word[15:8];
        res_lo_reg <= part_word[7:0];
      end
    end
  end

  // Interrupt, wake and output registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_reg    <= 1'b0;
      wake_reg   <= 1'b0;
      resume_reg <= 1'b0;
      isr_reg    <= 1'b0;
      on_out_reg <= 1'b0;
      sample_reg <= 1'b0;
    end else begin
      irq_reg    <= flag_next && irqen_reg;
      wake_reg   <= done_evt && core_sleeping && irqen_reg;
      // Next instruction runs first, the branch decision follows
      resume_reg <= wake_reg;
      isr_reg    <= resume_reg && gie_reg && peripheral_irq_enable_reg;
      on_out_reg <= on_reg && !pd_next;
      sample_reg <= on_reg && !pd_next && state_next != ST_CONV;
    end
  end

  assign hreadyout              = hreadyout_reg;
  assign hrdata                 = hrdata_reg;
  assign hresp                  = 1'b0;
  assign input_select           = sel_reg;
  assign upper_reference_select = pref_reg;
  assign lower_reference_select = nref_reg;
  assign converter_on           = on_out_reg;
  assign sample_connect         = sample_reg;
  assign sar_trial_code         = sar_reg;
  assign conversion_done_flag   = flag_reg;
  assign irq_request            = irq_reg;
  assign wake_request           = wake_reg;
  assign resume_next_instr      = resume_reg;
  assign isr_branch             = isr_reg;

  // hsize is accepted but ignored: every access is taken as a word
  wire unused_ok = &{1'b0, hsize};

endmodule
`default_nettype wire

// ==== sar_adc_pkg.sv ====
// Package for the converter control: register map, fields, reset
// values, clock select codes and conversion timing.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package sar_adc_pkg;

  localparam int RESULT_BITS = 10;

  // Byte addresses on the register bus
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_RES_HI  = 8'h08;
  localparam logic [7:0] ADDR_RES_LO  = 8'h0C;
  localparam logic [7:0] ADDR_FLAG    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
  localparam logic [7:0] ADDR_CORE    = 8'h18;

  // converter_control_0 fields
  localparam int CTRL0_ON_BIT  = 0;
  localparam int CTRL0_GO_BIT  = 1;
  localparam int CTRL0_SEL_LSB = 2;
  localparam int SEL_W         = 5;
  // converter_control_1 fields
  localparam int CTRL1_PREF_LSB = 0;
  localparam int PREF_W         = 2;
  localparam int CTRL1_NREF_BIT = 2;
  localparam int CTRL1_CS_LSB   = 4;
  localparam int CS_W           = 3;
  localparam int CTRL1_JUST_BIT = 7;
  // Flag, enable and core interrupt control fields
  localparam int FLAG_DONE_BIT  = 0;
  localparam int IRQ_EN_BIT     = 0;
  localparam int CORE_PERIPHERAL_IRQ_ENABLE_BIT  = 6;
  localparam int CORE_GIE_BIT   = 7;

  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] RES_RST   = 8'h00;

  // Conversion clock select codes
  localparam logic [2:0] CS_DIV2  = 3'h0;
  localparam logic [2:0] CS_DIV4  = 3'h4;
  localparam logic [2:0] CS_DIV8  = 3'h1;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  // Conversion timing in half bit periods: 11.5 periods = 23 halves
  localparam logic [4:0] CONV_LAST_HALF   = 5'h16;
  localparam logic [4:0] FIRST_DECIDE     = 5'h04;
  localparam logic [4:0] RC_START_HALVES  = 5'h02;
  localparam logic [RESULT_BITS-1:0] SAR_FIRST_MASK = 10'h200;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} conv_state_e;

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == CS_RC_LOW);
  endfunction

endpackage

// ==== tad_tick_gen.sv ====
// Half bit period tick generator for the converter.
// Assumes rc_half_tick is a one-cycle pulse synchronous to clock,
// one pulse per half period of the dedicated RC oscillator.
`timescale 1ns/1ps
`default_nettype none
module tad_tick_gen
  import sar_adc_pkg::*;
#(
  parameter int DIV_W = 5
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          run,
  input  wire logic [CS_W-1:0] clock_select,
  input  wire logic          rc_half_tick,
  output logic               half_tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;
  logic [DIV_W-1:0] limit;
  logic             rc_sel;

  // Half period minus one, in system clocks
  function automatic logic [DIV_W-1:0] half_limit(input logic [2:0] s);
    case (s)
      CS_DIV2:  half_limit = DIV_W'(0);
      CS_DIV4:  half_limit = DIV_W'(1);
      CS_DIV8:  half_limit = DIV_W'(3);
      CS_DIV16: half_limit = DIV_W'(7);
      CS_DIV32: half_limit = DIV_W'(15);
      CS_DIV64: half_limit = DIV_W'(31);
      default:  half_limit = DIV_W'(0);
    endcase
  endfunction

  // Divider codes derive from clock, so their period tracks any clock change; RC codes follow rc_half_tick
  assign limit    = half_limit(clock_select);
  assign rc_sel   = is_rc(clock_select);
  assign cnt_next = (!run || cnt_reg == limit) ? '0 : cnt_reg + 1'b1;
  assign tick_next = run && (rc_sel ? rc_half_tick : cnt_reg == limit);
  assign half_tick = tick_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes the analog source model and a bus with this one slave.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sar_adc_pkg::*;
;
  logic        clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic        compare_high, rc_half_tick, core_sleeping, converter_on;
  logic        sample_connect, conversion_done_flag, irq_request;
  logic        wake_request, resume_next_instr, isr_branch;
  logic        lower_reference_select;
  logic [1:0]  htrans, upper_reference_select;
  logic [2:0]  hsize;
  logic [4:0]  input_select;
  logic [9:0]  sar_trial_code;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0]  woke = 4'h0;
  logic [3:0]  isrs = 4'h0;
  int          err_total, total_checks, n;
  typedef struct {logic [4:0] sel; logic [2:0] cs; logic just;
                  logic [7:0] hi; logic [7:0] lo; int h;} row_s;
  // Every clock code; fast dividers are fine here, no analog timing
  row_s rows [8] = '{'{5'h00,3'h0,1'b1,8'h00,8'h00,1},
    '{5'h1F,3'h4,1'b0,8'hFF,8'hC0,2}, '{5'h0D,3'h1,1'b1,8'h01,8'hAD,4},
    '{5'h1E,3'h5,1'b0,8'hF7,8'h80,8}, '{5'h1D,3'h2,1'b1,8'h03,8'hBD,16},
    '{5'h15,3'h6,1'b0,8'hAD,8'h40,32}, '{5'h0A,3'h3,1'b0,8'h52,8'h80,0},
    '{5'h01,3'h7,1'b1,8'h00,8'h21,0}};
  assign hready = hreadyout;
  sar_adc_control dut_u (.*);
  analog_source_model src_u (.clock(clock), .nrst(nrst),
    .input_select(input_select), .sar_trial_code(sar_trial_code),
    .compare_high(compare_high), .rc_half_tick(rc_half_tick));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wake_request) woke <= woke + 4'h1;
    if (isr_branch) isrs <= isrs + 4'h1;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for hready high at an edge; read data is taken with it
  task automatic wt;
    int k;
    k = 0;
    @(negedge clock);
    while (hreadyout !== 1'b1 && k < 50) begin
      k++;
      @(negedge clock);
    end
    rd = hrdata;
    if (k >= 50) begin
      err_total++;
      finish_test;
    end
    @(posedge clock);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wt;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic wfl;
    n = 0;
    while (conversion_done_flag !== 1'b1 && n < 3000) begin
      n++;
      @(negedge clock);
    end
    if (n >= 3000) begin
      err_total++;
      finish_test;
    end
    @(posedge clock);
  endtask
  initial begin
    {nrst, hsel, haddr, htrans, hwrite, hwdata, core_sleeping} = '0;
    hsize = 3'h2;
    repeat (20) @(posedge clock);
    chk(32'(hreadyout), 32'h1);
    nrst <= 1'b1;
    @(posedge clock);
    rdc(ADDR_CTRL0, 32'h0);
    rdc(ADDR_CTRL1, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1, ADDR_CTRL1, {rows[i].just, rows[i].cs, 1'b0, i[1], i[0], 1'b0});
      bus(1, ADDR_CTRL0, 8'h01);
      bus(1, ADDR_CTRL0, {1'b0, rows[i].sel, 2'b01});
      repeat (8) @(posedge clock);
      chk(32'(input_select), 32'(rows[i].sel));
      chk(32'({converter_on, sample_connect}), 32'h3);
      chk(32'({upper_reference_select, lower_reference_select}),
          32'({i[0], 1'b0, i[1]}));
      bus(1, ADDR_FLAG, 8'h00);
      bus(1, ADDR_CTRL0, {1'b0, rows[i].sel, 2'b11});
      wfl;
      if (rows[i].h != 0) chk(32'(n >= 23 * rows[i].h - 2 &&
          n <= 23 * rows[i].h + 3), 32'h1);
      rdc(ADDR_CTRL0, {1'b0, rows[i].sel, 2'b01});
      rdc(ADDR_RES_HI, rows[i].hi);
      rdc(ADDR_RES_LO, rows[i].lo);
      rdc(ADDR_FLAG, 32'h1);
    end
    bus(1, ADDR_CTRL0, 8'h00);
    bus(1, ADDR_CTRL0, 8'h02);
    rdc(ADDR_CTRL0, 32'h0);
    bus(1, 8'h1C, 8'hFF);
    rdc(8'h1C, 32'h0);
    bus(1, ADDR_CTRL1, 8'hE0);
    bus(1, ADDR_CTRL0, 8'h7D);
    bus(1, ADDR_CTRL0, 8'h7F);
    rdc(ADDR_RES_LO, 32'h21);
    chk(32'({sample_connect, sar_trial_code}), 32'h200);
    repeat (300) @(posedge clock);
    bus(1, ADDR_CTRL0, 8'h7D);
    repeat (4) @(posedge clock);
    rdc(ADDR_CTRL0, 32'h7D);
    rdc(ADDR_RES_HI, 32'h03);
    rdc(ADDR_RES_LO, 32'hFF);
    bus(1, ADDR_FLAG, 8'h00);
    bus(1, ADDR_CTRL0, 8'h7F);
    core_sleeping <= 1'b1;
    repeat (20) @(posedge clock);
    chk(32'(converter_on), 32'h0);
    core_sleeping <= 1'b0;
    rdc(ADDR_CTRL0, 32'h7D);
    rdc(ADDR_FLAG, 32'h0);
    bus(1, ADDR_IRQ_EN, 8'h01);
    bus(1, ADDR_CORE, 8'hC0);
    bus(1, ADDR_CTRL1, 8'hB0);
    bus(1, ADDR_CTRL0, 8'h7F);
    core_sleeping <= 1'b1;
    wfl;
    repeat (4) @(posedge clock);
    chk(32'(woke), 32'h1);
    chk(32'(isrs), 32'h1);
    chk(32'(irq_request), 32'h1);
    core_sleeping <= 1'b0;
    bus(1, ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge clock);
    chk(32'(irq_request), 32'h0);
    rdc(ADDR_FLAG, 32'h1);
    bus(1, ADDR_FLAG, 8'h00);
    rdc(ADDR_FLAG, 32'h0);
    // Global enable off: wake continues in line, no handler branch
    bus(1, ADDR_CORE, 8'h40);
    bus(1, ADDR_IRQ_EN, 8'h01);
    bus(1, ADDR_CTRL0, 8'h7F);
    core_sleeping <= 1'b1;
    wfl;
    repeat (4) @(posedge clock);
    chk(32'(woke), 32'h2);
    chk(32'(isrs), 32'h1);
    core_sleeping <= 1'b0;
    finish_test;
  end
endmodule
`default_nettype wire
